// file: src/cscr_regs.sv
/*
  CPU status flags and core control register bank with event interrupt.
  Assumes the ALU, loop and interrupt logic share clk; register port
  answers reads one cycle later.
*/
`timescale 1ns/1ns
module cscr_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic alu_valid,
  input wire logic alu_sub,
  input wire logic [15:0] alu_opa,
  input wire logic [15:0] alu_opb,
  input wire logic repeat_busy,
  input wire logic do_loop_busy,
  input wire logic acc_a_ovf,
  input wire logic acc_b_ovf,
  input wire logic acc_a_sat,
  input wire logic acc_b_sat,
  input wire logic [2:0] loop_nest_level,
  input wire logic stack_frame_on,
  input wire logic ipl_load,
  input wire logic [3:0] ipl_load_value,
  output logic [3:0] cpu_priority,
  output logic user_irq_blocked,
  output logic [15:0] core_control,
  output logic early_terminate,
  output logic irq
);
  cscr_alu_if alu_if ();

  localparam int IRQ_W_L = cscr_pkg::IRQ_W;
  logic [2:0] cpu_priority_field_q;
  logic [2:0] cpu_priority_field_d;
  logic cpu_priority_high_bit_q;
  logic cpu_priority_high_bit_d;
  logic repeat_active_flag_q;
  logic do_active_q;
  logic neg_q;
  logic signed_overflow_flag_q;
  logic zero_q;
  logic carry_q;
  logic half_carry_q;
  logic acc_a_ovf_q;
  logic acc_b_ovf_q;
  logic acc_a_sat_sticky_q;
  logic acc_b_sat_sticky_q;
  logic acc_any_sat_sticky;
  logic nesting_disable_q;
  logic [15:0] core_ctrl_q;
  logic [IRQ_W_L-1:0] irq_stat_q;
  logic [IRQ_W_L-1:0] irq_stat_d;
  logic [IRQ_W_L-1:0] irq_mask_q;
  logic [IRQ_W_L-1:0] irq_event;
  logic [15:0] status_word;
  logic [15:0] core_word;
  logic wr_status;
  logic wr_core;

  ////////////////////////////////////////////////////////////////////////
  // Flag unit
  assign alu_if.valid = alu_valid;
  assign alu_if.sub = alu_sub;
  assign alu_if.opa = alu_opa;
  assign alu_if.opb = alu_opb;

  cscr_alu_flags u_flags (
    .alu(alu_if.unit)
  );

  // Write decode
  assign wr_status = reg_wr && (reg_addr == cscr_pkg::OFF_STATUS);
  assign wr_core = reg_wr && (reg_addr == cscr_pkg::OFF_CORE);

  ////////////////////////////////////////////////////////////////////////
  // Priority next value: interrupt logic load beats software
  always_comb begin
    cpu_priority_field_d = cpu_priority_field_q;
    cpu_priority_high_bit_d = cpu_priority_high_bit_q;
    if (ipl_load) begin
      cpu_priority_field_d = ipl_load_value[2:0];
      cpu_priority_high_bit_d = ipl_load_value[3];
    end else begin
      if (wr_status && !nesting_disable_q) begin
        cpu_priority_field_d = reg_wdata[cscr_pkg::ST_IPL_HI:cscr_pkg::ST_IPL_LO];
      end
      if (wr_core) begin
        cpu_priority_high_bit_d = cpu_priority_high_bit_q & reg_wdata[cscr_pkg::CC_CPU_PRIORITY_HIGH_BIT];
      end
    end
  end

  // Priority registers and blocking output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_priority_field_q <= cscr_pkg::IPL_RESET;
      cpu_priority_high_bit_q <= 1'b0;
      user_irq_blocked <= 1'b0;
    end else begin
      cpu_priority_field_q <= cpu_priority_field_d;
      cpu_priority_high_bit_q <= cpu_priority_high_bit_d;
      user_irq_blocked <= cpu_priority_high_bit_d || (cpu_priority_field_d == cscr_pkg::IPL_TOP);
    end
  end

  assign cpu_priority = {cpu_priority_high_bit_q, cpu_priority_field_q};

  ////////////////////////////////////////////////////////////////////////
  // Loop activity and accumulator overflow levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      repeat_active_flag_q <= 1'b0;
      do_active_q <= 1'b0;
      acc_a_ovf_q <= 1'b0;
      acc_b_ovf_q <= 1'b0;
    end else begin
      repeat_active_flag_q <= repeat_busy;
      do_active_q <= do_loop_busy;
      acc_a_ovf_q <= acc_a_ovf;
      acc_b_ovf_q <= acc_b_ovf;
    end
  end

  // ALU flags: ALU update wins over a software write in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      neg_q <= 1'b0;
      signed_overflow_flag_q <= 1'b0;
      carry_q <= 1'b0;
      half_carry_q <= 1'b0;
    end else if (alu_valid) begin
      neg_q <= alu_if.neg;
      signed_overflow_flag_q <= alu_if.ovf;
      carry_q <= alu_if.carry;
      half_carry_q <= alu_if.half_carry;
    end else if (wr_status) begin
      neg_q <= reg_wdata[cscr_pkg::ST_N];
      signed_overflow_flag_q <= reg_wdata[cscr_pkg::ST_OV];
      carry_q <= reg_wdata[cscr_pkg::ST_C];
      half_carry_q <= reg_wdata[cscr_pkg::ST_DC];
    end
  end

  // Sticky zero: a non-zero result clears it, no result sets it; status writes load it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_q <= 1'b0;
    end else if (alu_valid && alu_if.nonzero) begin
      zero_q <= 1'b0;
    end else if (wr_status) begin
      zero_q <= reg_wdata[cscr_pkg::ST_Z];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Saturation stickies: hardware set wins over any write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_a_sat_sticky_q <= 1'b0;
      acc_b_sat_sticky_q <= 1'b0;
    end else begin
      if (acc_a_sat) begin
        acc_a_sat_sticky_q <= 1'b1;
      end else if (wr_status) begin
        acc_a_sat_sticky_q <= reg_wdata[cscr_pkg::ST_SA] & reg_wdata[cscr_pkg::ST_SAB];
      end
      if (acc_b_sat) begin
        acc_b_sat_sticky_q <= 1'b1;
      end else if (wr_status) begin
        acc_b_sat_sticky_q <= reg_wdata[cscr_pkg::ST_SB] & reg_wdata[cscr_pkg::ST_SAB];
      end
    end
  end

  assign acc_any_sat_sticky = acc_a_sat_sticky_q | acc_b_sat_sticky_q;

  ////////////////////////////////////////////////////////////////////////
  // Core control and nesting disable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_ctrl_q <= cscr_pkg::CC_RESET;
      nesting_disable_q <= 1'b0;
    end else begin
      if (wr_core) begin
        core_ctrl_q <= reg_wdata & cscr_pkg::CC_WR_MASK;
      end
      if (reg_wr && (reg_addr == cscr_pkg::OFF_ICON)) begin
        nesting_disable_q <= reg_wdata[cscr_pkg::IC_NESTING_DISABLE];
      end
    end
  end

  // Early loop terminate: write of one gives a pulse, reads as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      early_terminate <= 1'b0;
    end else begin
      early_terminate <= wr_core && reg_wdata[cscr_pkg::CC_EDT];
    end
  end

  // Read views
  always_comb begin
    core_word = core_ctrl_q;
    core_word[cscr_pkg::CC_DL_HI:cscr_pkg::CC_DL_LO] = loop_nest_level;
    core_word[cscr_pkg::CC_SFA] = stack_frame_on;
    core_word[cscr_pkg::CC_CPU_PRIORITY_HIGH_BIT] = cpu_priority_high_bit_q;
  end

  always_comb begin
    status_word = 16'h0000;
    status_word[cscr_pkg::ST_OA] = acc_a_ovf_q;
    status_word[cscr_pkg::ST_OB] = acc_b_ovf_q;
    status_word[cscr_pkg::ST_SA] = acc_a_sat_sticky_q;
    status_word[cscr_pkg::ST_SB] = acc_b_sat_sticky_q;
    status_word[cscr_pkg::ST_OAB] = acc_a_ovf_q | acc_b_ovf_q;
    status_word[cscr_pkg::ST_SAB] = acc_any_sat_sticky;
    status_word[cscr_pkg::ST_DA] = do_active_q;
    status_word[cscr_pkg::ST_DC] = half_carry_q;
    status_word[cscr_pkg::ST_IPL_HI:cscr_pkg::ST_IPL_LO] = cpu_priority_field_q;
    status_word[cscr_pkg::ST_RA] = repeat_active_flag_q;
    status_word[cscr_pkg::ST_N] = neg_q;
    status_word[cscr_pkg::ST_OV] = signed_overflow_flag_q;
    status_word[cscr_pkg::ST_Z] = zero_q;
    status_word[cscr_pkg::ST_C] = carry_q;
  end

  // Core control output mirrors the readable view
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_control <= cscr_pkg::CC_RESET;
    end else begin
      core_control <= core_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status, write one to clear, set wins
  assign irq_event[cscr_pkg::IRQ_SAT_A] = acc_a_sat;
  assign irq_event[cscr_pkg::IRQ_SAT_B] = acc_b_sat;
  assign irq_event[cscr_pkg::IRQ_OV] = alu_valid && alu_if.ovf;

  always_comb begin
    irq_stat_d = irq_stat_q;
    if (reg_wr && (reg_addr == cscr_pkg::OFF_IRQ_STAT)) begin
      irq_stat_d = irq_stat_q & ~reg_wdata[IRQ_W_L-1:0];
    end
    irq_stat_d = irq_stat_d | irq_event;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (reg_wr && (reg_addr == cscr_pkg::OFF_IRQ_MASK)) begin
        irq_mask_q <= reg_wdata[IRQ_W_L-1:0];
      end
      irq <= |(irq_stat_d & ((reg_wr && (reg_addr == cscr_pkg::OFF_IRQ_MASK)) ?
                             reg_wdata[IRQ_W_L-1:0] : irq_mask_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: data stand one cycle, zero otherwise and when unmapped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else begin
      unique case (reg_addr)
        cscr_pkg::OFF_STATUS: reg_rdata <= status_word;
        cscr_pkg::OFF_CORE: reg_rdata <= core_word;
        cscr_pkg::OFF_ICON: reg_rdata <= {nesting_disable_q, 15'h0000};
        cscr_pkg::OFF_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat_q};
        cscr_pkg::OFF_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_BLOCKED: assert property (user_irq_blocked == (cpu_priority[3] || cpu_priority[2:0] == 3'h7))
    else $error("blocking output disagrees with priority");
  AST_IPL_WRITE: assert property (wr_status && !nesting_disable_q && !ipl_load |=>
      cpu_priority[2:0] == $past(reg_wdata[7:5]))
    else $error("priority field write lost");
  AST_IPL_LOCK: assert property (wr_status && nesting_disable_q && !ipl_load |=> $stable(cpu_priority[2:0]))
    else $error("priority field written while locked");
  AST_IPL_LOAD: assert property (ipl_load |=> cpu_priority == $past(ipl_load_value))
    else $error("priority load not applied");
  AST_CPU_PRIORITY_HIGH_BIT_CLR_ONLY: assert property (!cpu_priority[3] && !ipl_load |=> !cpu_priority[3])
    else $error("high priority bit set by software");
  AST_RA: assert property (repeat_busy ##1 (reg_rd && reg_addr == cscr_pkg::OFF_STATUS) |=>
      reg_rdata[cscr_pkg::ST_RA])
    else $error("repeat flag not shown in status");
  AST_RA_FOLLOW: assert property (##1 repeat_active_flag_q == $past(repeat_busy))
    else $error("repeat flag not following loop");
  AST_NEG: assert property (alu_valid && !alu_sub && alu_opb == 16'h0000 |=> neg_q == $past(alu_opa[15]))
    else $error("negative flag wrong");
  AST_OVF: assert property (alu_valid && !alu_sub && alu_opa == 16'h7FFF && alu_opb == 16'h0001 |=>
      signed_overflow_flag_q && neg_q)
    else $error("signed overflow missed");
  AST_ZERO_STICKY: assert property (!zero_q && !wr_status |=> !zero_q)
    else $error("zero flag set by operation");
  AST_CARRY: assert property (alu_valid && !alu_sub && alu_opa[15] && alu_opb[15] |=> carry_q)
    else $error("carry missed");
  AST_SAB_CLEAR: assert property (wr_status && !reg_wdata[10] && !acc_a_sat && !acc_b_sat |=>
      !acc_a_sat_sticky_q && !acc_b_sat_sticky_q)
    else $error("combined clear did not clear stickies");
  AST_SAT_HOLD: assert property (acc_any_sat_sticky && !wr_status |=> acc_any_sat_sticky)
    else $error("saturation sticky lost");
  AST_SAT_SET: assert property (acc_a_sat |=> acc_a_sat_sticky_q && acc_any_sat_sticky)
    else $error("saturation sticky not set");
  AST_CC_RO: assert property (##1 (core_control[10:8] == $past(loop_nest_level) &&
      core_control[cscr_pkg::CC_SFA] == $past(stack_frame_on) && !core_control[cscr_pkg::CC_EDT]))
    else $error("loop nesting field not read-only");

  COV_HIGH_LEVEL: cover property (ipl_load && ipl_load_value[3] ##1 user_irq_blocked);
  COV_SAB_CLEAR: cover property (acc_any_sat_sticky && wr_status && !reg_wdata[10]);
  COV_ZERO_CLEAR: cover property (zero_q && alu_valid && alu_if.nonzero);
  COV_IRQ: cover property ($rose(irq));
endmodule

// file: common/cscr_pkg.sv
/*
  Constants for the status flag and core control register bank.
  Assumes a 16-bit register port on a single clock.
*/
package cscr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CORE = 8'h04;
  localparam logic [7:0] OFF_ICON = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  // Status register fields
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_OV = 2;
  localparam int ST_N = 3;
  localparam int ST_RA = 4;
  localparam int ST_IPL_LO = 5;
  localparam int ST_IPL_HI = 7;
  localparam int ST_DC = 8;
  localparam int ST_DA = 9;
  localparam int ST_SAB = 10;
  localparam int ST_OAB = 11;
  localparam int ST_SB = 12;
  localparam int ST_SA = 13;
  localparam int ST_OB = 14;
  localparam int ST_OA = 15;
  // Core control fields and the OFF_ICON nesting disable bit
  localparam int CC_CPU_PRIORITY_HIGH_BIT = 3;
  localparam int CC_SFA = 2;
  localparam int CC_DL_LO = 8;
  localparam int CC_DL_HI = 10;
  localparam int CC_EDT = 11;
  localparam int IC_NESTING_DISABLE = 15;
  // Reset values, write masks and the top priority level
  localparam logic [15:0] CC_RESET = 16'h0020;
  localparam logic [15:0] CC_WR_MASK = 16'hB0F3;
  localparam logic [2:0] IPL_RESET = 3'h0;
  localparam logic [2:0] IPL_TOP = 3'h7;
  // Event status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_SAT_A = 0;
  localparam int IRQ_SAT_B = 1;
  localparam int IRQ_OV = 2;
endpackage

// file: common/cscr_alu_if.sv
/*
  Carrier between the register bank and its ALU flag unit.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface cscr_alu_if;
  logic valid;
  logic sub;
  logic [15:0] opa;
  logic [15:0] opb;
  logic neg;
  logic ovf;
  logic nonzero;
  logic carry;
  logic half_carry;
  modport core (output valid, output sub, output opa, output opb,
                input neg, input ovf, input nonzero, input carry, input half_carry);
  modport unit (input valid, input sub, input opa, input opb,
                output neg, output ovf, output nonzero, output carry, output half_carry);
endinterface

// file: src/cscr_alu_flags.sv
/*
  Combinational flag calculation for a 16-bit add or subtract.
  Assumes the register bank samples the flags when valid is high.
*/
`timescale 1ns/1ns
module cscr_alu_flags (
  cscr_alu_if.unit alu
);
  logic [15:0] opb_eff;
  logic [16:0] sum;
  logic [8:0] low_sum;

  // Subtract is add of inverted operand plus one
  always_comb begin
    opb_eff = alu.sub ? ~alu.opb : alu.opb;
    sum = {1'b0, alu.opa} + {1'b0, opb_eff} + {16'h0000, alu.sub};
    low_sum = {1'b0, alu.opa[7:0]} + {1'b0, opb_eff[7:0]} + {8'h00, alu.sub};
  end

  // Flag outputs
  assign alu.neg = sum[15];
  assign alu.ovf = (alu.opa[15] == opb_eff[15]) && (sum[15] != alu.opa[15]);
  assign alu.nonzero = |sum[15:0];
  assign alu.carry = sum[16];
  assign alu.half_carry = low_sum[8];
endmodule

// file: test/cscr_cpu_model.sv
/*
  Model of the CPU side of the flag bank: ALU results, repeat loop state,
  accumulator saturation events and priority loads.
  Assumes the bank samples every input on the rising edge of clk.
*/
`timescale 1ns/1ns
module cscr_cpu_model (
  input wire logic clk,
  output logic alu_valid,
  output logic alu_sub,
  output logic [15:0] alu_opa,
  output logic [15:0] alu_opb,
  output logic repeat_busy,
  output logic acc_a_sat,
  output logic acc_b_sat,
  output logic ipl_load,
  output logic [3:0] ipl_load_value
);
  // Quiet outputs at time zero
  initial begin
    alu_valid = 1'b0;
    alu_sub = 1'b0;
    alu_opa = 16'h0000;
    alu_opb = 16'h0000;
    repeat_busy = 1'b0;
    acc_a_sat = 1'b0;
    acc_b_sat = 1'b0;
    ipl_load = 1'b0;
    ipl_load_value = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One ALU result; operands scrambled once the pulse is over
  task automatic alu_op(input logic sub, input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    alu_valid <= 1'b1;
    alu_sub <= sub;
    alu_opa <= a;
    alu_opb <= b;
    @(posedge clk);
    alu_valid <= 1'b0;
    alu_opa <= ~a;
    alu_opb <= ~b;
    #1;
  endtask

  // Event pulse: 0 saturates acc A, 1 acc B, 2 loads a priority
  task automatic pulse(input int which, input logic [3:0] v);
    @(posedge clk);
    acc_a_sat <= (which == 0);
    acc_b_sat <= (which == 1);
    ipl_load <= (which == 2);
    ipl_load_value <= v;
    @(posedge clk);
    acc_a_sat <= 1'b0;
    acc_b_sat <= 1'b0;
    ipl_load <= 1'b0;
    ipl_load_value <= ~v;
    #1;
  endtask

  // Repeat loop start or end
  task automatic set_repeat(input logic v);
    @(posedge clk);
    repeat_busy <= v;
    #1;
  endtask
endmodule

// file: test/cscr_regs_bench.sv
/*
  Self-checking bench for the status flag and core control bank.
  Assumes the CPU model drives the ALU, repeat, saturation and priority inputs; the bench owns the register port and the loop and overflow levels.
*/
`timescale 1ns/1ns
module cscr_regs_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] nest = 3'h0;
  logic frame_on = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic [15:0] reg_rdata, core_control, alu_opa, alu_opb, rd_val, core_exp;
  logic [3:0] cpu_priority, ipl_load_value;
  logic alu_valid, alu_sub, repeat_busy, acc_a_sat, acc_b_sat, ipl_load;
  logic user_irq_blocked, early_terminate, irq;
  int bad_count = 0;
  int samples_checked = 0;
  // Reference model state
  bit [2:0] m_prio, m_ev, m_mask;
  bit m_prio_hi, m_rep, m_neg, m_ovf, m_zero, m_carry, m_half, m_sat_a, m_sat_b, m_nst;
  bit [32:0] ops[4] = '{{1'b1, 16'h1234, 16'h1234}, {1'b0, 16'h7FFF, 16'h0001},
                        {1'b0, 16'hFFFF, 16'h0001}, {1'b1, 16'h8000, 16'h0001}};

  // Clock
  always #50 clk = ~clk;

  cscr_regs i_cscr_regs (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_valid(alu_valid),
    .alu_sub(alu_sub), .alu_opa(alu_opa), .alu_opb(alu_opb), .repeat_busy(repeat_busy),
    .do_loop_busy(lvl[2]), .acc_a_ovf(lvl[1]), .acc_b_ovf(lvl[0]), .acc_a_sat(acc_a_sat),
    .acc_b_sat(acc_b_sat), .loop_nest_level(nest), .stack_frame_on(frame_on),
    .ipl_load(ipl_load), .ipl_load_value(ipl_load_value), .cpu_priority(cpu_priority),
    .user_irq_blocked(user_irq_blocked), .core_control(core_control),
    .early_terminate(early_terminate), .irq(irq));

  cscr_cpu_model i_cscr_cpu_model (.clk(clk), .alu_valid(alu_valid), .alu_sub(alu_sub),
    .alu_opa(alu_opa), .alu_opb(alu_opb), .repeat_busy(repeat_busy), .acc_a_sat(acc_a_sat),
    .acc_b_sat(acc_b_sat), .ipl_load(ipl_load), .ipl_load_value(ipl_load_value));

  ////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic chk_reg(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_pins;
    chk_reg("priority", {12'h000, m_prio_hi, m_prio}, {12'h000, cpu_priority});
    chk_reg("blocked", {15'h0000, m_prio_hi | (m_prio == 3'h7)}, {15'h0000, user_irq_blocked});
    chk_reg("irq", {15'h0000, |(m_ev & m_mask)}, {15'h0000, irq});
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Whole-word status write and its effect on the model
  task automatic wr_status(input logic [15:0] d);
    wr(cscr_pkg::OFF_STATUS, d);
    {m_half, m_neg, m_ovf, m_zero, m_carry} = {d[8], d[3:0]};
    if (!m_nst) m_prio = d[7:5];
    m_sat_a = d[13] & d[10];
    m_sat_b = d[12] & d[10];
  endtask

  task automatic chk_status;
    rd(cscr_pkg::OFF_STATUS, rd_val);
    chk_reg("status", {lvl[1], lvl[0], m_sat_a, m_sat_b, lvl[1] | lvl[0], m_sat_a | m_sat_b, lvl[2], m_half, m_prio,
      m_rep, m_neg, m_ovf, m_zero, m_carry}, rd_val);
    chk_pins();
  endtask

  task automatic chk_events;
    rd(cscr_pkg::OFF_IRQ_STAT, rd_val);
    chk_reg("events", {13'h0000, m_ev}, rd_val);
    chk_pins();
  endtask

  // ALU result through the model, flags from carry arithmetic
  task automatic alu(input bit sub, input bit [15:0] a, input bit [15:0] b);
    bit [15:0] bb;
    bit [16:0] s;
    bit [8:0] h;
    bb = sub ? ~b : b;
    s = a + bb + sub;
    h = a[7:0] + bb[7:0] + sub;
    i_cscr_cpu_model.alu_op(sub, a, b);
    {m_carry, m_half, m_neg} = {s[16], h[8], s[15]};
    m_ovf = (a[15] == bb[15]) && (s[15] != a[15]);
    if (s[15:0] != 16'h0000) m_zero = 1'b0;
    if (m_ovf) m_ev[cscr_pkg::IRQ_OV] = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    #(5000 * 100);
    bad_count++;
    final_report();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h9E8C4027));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_status();
    rd(cscr_pkg::OFF_CORE, rd_val);
    chk_reg("core", cscr_pkg::CC_RESET, rd_val);
    wr(8'h14, 16'hFFFF);
    rd(8'h14, rd_val);
    chk_reg("unmapped", 16'h0000, rd_val);
    for (int i = 0; i < 8; i++) begin
      wr_status(16'(i << 5));
      chk_status();
    end
    // Priority load above 7, then core control writes
    i_cscr_cpu_model.pulse(2, 4'h9);
    {m_prio_hi, m_prio} = 4'h9;
    chk_pins();
    @(posedge clk);
    nest <= 3'($urandom);
    frame_on <= 1'b1;
    wr(cscr_pkg::OFF_CORE, 16'hFFFF);
    chk_reg("early_terminate", 16'h0001, {15'h0000, early_terminate});
    // Core control output lags the register by one cycle
    @(posedge clk);
    #1;
    core_exp = 16'hB0FB | {5'h00, nest, 8'h00} | 16'h0004;
    chk_reg("core_port", core_exp, core_control);
    rd(cscr_pkg::OFF_CORE, rd_val);
    chk_reg("core", core_exp, rd_val);
    wr(cscr_pkg::OFF_CORE, 16'h0000);
    wr(cscr_pkg::OFF_CORE, 16'h0008);
    m_prio_hi = 1'b0;
    rd(cscr_pkg::OFF_CORE, rd_val);
    chk_reg("core", {5'h00, nest, 8'h04}, rd_val);
    chk_pins();
    // Priority field frozen while nesting is disabled
    wr(cscr_pkg::OFF_ICON, 16'h8000);
    m_nst = 1'b1;
    wr_status(16'h00E2);
    chk_status();
    wr(cscr_pkg::OFF_ICON, 16'h0000);
    m_nst = 1'b0;
    // Directed then random ALU results, zero flag set by software first
    wr(cscr_pkg::OFF_IRQ_MASK, 16'h0007);
    m_mask = 3'h7;
    for (int i = 0; i < 28; i++) begin
      if (i < 4) alu(ops[i][32], ops[i][31:16], ops[i][15:0]);
      else alu(1'($urandom), 16'($urandom), 16'($urandom));
      chk_status();
    end
    chk_events();
    wr(cscr_pkg::OFF_IRQ_STAT, 16'h0004);
    m_ev[cscr_pkg::IRQ_OV] = 1'b0;
    chk_events();
    // Repeat loop activity
    i_cscr_cpu_model.set_repeat(1'b1);
    m_rep = 1'b1;
    chk_status();
    i_cscr_cpu_model.set_repeat(1'b0);
    m_rep = 1'b0;
    chk_status();
    // Loop and accumulator overflow mirrors: random, all set, then clear
    @(posedge clk);
    lvl <= 3'($urandom);
    chk_status();
    @(posedge clk);
    lvl <= 3'h7;
    chk_status();
    @(posedge clk);
    lvl <= 3'h0;
    chk_status();
    // Saturation stickies and the event interrupt
    i_cscr_cpu_model.pulse(0, 4'h0);
    {m_sat_a, m_ev[cscr_pkg::IRQ_SAT_A]} = 2'b11;
    chk_status();
    chk_events();
    wr(cscr_pkg::OFF_IRQ_MASK, 16'h0000);
    m_mask = 3'h0;
    i_cscr_cpu_model.pulse(1, 4'h0);
    {m_sat_b, m_ev[cscr_pkg::IRQ_SAT_B]} = 2'b11;
    chk_status();
    chk_events();
    wr(cscr_pkg::OFF_IRQ_STAT, 16'h0003);
    m_ev = 3'h0;
    wr(cscr_pkg::OFF_IRQ_MASK, 16'h0003);
    m_mask = 3'h3;
    chk_events();
    wr_status(16'h0000);
    chk_status();
    wr_status(16'h3400);
    chk_status();
    wr_status(16'h3000);
    chk_status();
    final_report();
  end
endmodule
